// *** logic/uefcc_top.sv ***
// Endpoint request flags and USB clock control register bank
//
// Notes on behaviour
// - Endpoint access sets its request flag and raises the USB interrupt if its mask bit is set, usb_int_enable is high and stack_full is low.
// - Status bits 0..2 hold endpoint 0..2 flags, read/write, reset zero.
// - Status bits 3..7 always read zero.
// - Control bits 0..2 select endpoint FIFO 0, 1 or 2; reset zero.
// - Codes 011..111 reserved; no FIFO selected for them.
// - Control bit 3 enables USB clock when one; reset zero.
// - Control bit 4 requests deeper suspend power; software sets it in halt.
// - Control bit 5 selects PLL 24MHz clock when one, oscillator when zero.
`timescale 1ns/10ps
`default_nettype none
module uefcc_top
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] ep_access,
  input  wire logic       usb_int_enable,
  input  wire logic       stack_full,
  output logic            usb_irq,
  output logic      [2:0] fifo_endpoint_select,
  output logic            fifo_select_valid,
  output logic            usb_clock_gate,
  output logic            deep_suspend_power,
  output logic            pll_clock_source_select,
  output logic            crystal_freq_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  function automatic logic sel_valid(input logic [2:0] sel);
    case (sel)
      uefcc_pkg::SEL_EP0: sel_valid = 1'b1;
      uefcc_pkg::SEL_EP1: sel_valid = 1'b1;
      uefcc_pkg::SEL_EP2: sel_valid = 1'b1;
      default:            sel_valid = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] sticky_update(input logic [2:0] cur,
                                               input logic [2:0] clr,
                                               input logic [2:0] hit);
    sticky_update = (cur & ~clr) | hit;
  endfunction

  function automatic logic [7:0] pad_low3(input logic [2:0] val);
    pad_low3 = {5'h00, val};
  endfunction

  function automatic logic [7:0] pack_ctrl(input logic [2:0] sel,
                                           input logic       gate,
                                           input logic       susp,
                                           input logic       pll,
                                           input logic       xtal);
    pack_ctrl = {1'b0, xtal, pll, susp, gate, sel};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic       wr_status;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       wr_istat;
  logic       rd_status;
  logic       rd_ctrl;
  logic       rd_mask;
  logic       rd_istat;
  logic       irq_gate;

  assign wr_status = reg_wr && addr_hit(reg_addr, uefcc_pkg::EP_STATUS_OFFSET);
  assign wr_ctrl   = reg_wr && addr_hit(reg_addr, uefcc_pkg::CLOCK_CTRL_OFFSET);
  assign wr_mask   = reg_wr && addr_hit(reg_addr, uefcc_pkg::IRQ_MASK_OFFSET);
  assign wr_istat  = reg_wr && addr_hit(reg_addr, uefcc_pkg::IRQ_STATUS_OFFSET);

  assign rd_status = reg_rd && addr_hit(reg_addr, uefcc_pkg::EP_STATUS_OFFSET);
  assign rd_ctrl   = reg_rd && addr_hit(reg_addr, uefcc_pkg::CLOCK_CTRL_OFFSET);
  assign rd_mask   = reg_rd && addr_hit(reg_addr, uefcc_pkg::IRQ_MASK_OFFSET);
  assign rd_istat  = reg_rd && addr_hit(reg_addr, uefcc_pkg::IRQ_STATUS_OFFSET);

  assign irq_gate  = usb_int_enable && !stack_full;

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint flags
  uefcc_flag_if fif ();

  assign fif.set_pulse = ep_access;
  assign fif.wr_en     = wr_status;
  assign fif.clr_mask  = reg_wdata[uefcc_pkg::EP_COUNT-1:0];

  uefcc_flags u_flags
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .fl      (fif.flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock control register
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic       gate_reg;
  logic       gate_next;
  logic       susp_reg;
  logic       susp_next;
  logic       pll_reg;
  logic       pll_next;
  logic       xtal_reg;
  logic       xtal_next;

  always_comb
  begin
    sel_next  = sel_reg;
    gate_next = gate_reg;
    susp_next = susp_reg;
    pll_next  = pll_reg;
    xtal_next = xtal_reg;
    if (wr_ctrl)
    begin
      sel_next  = reg_wdata[uefcc_pkg::SEL_MSB:uefcc_pkg::SEL_LSB];
      gate_next = reg_wdata[uefcc_pkg::USB_CLK_GATE_BIT];
      susp_next = reg_wdata[uefcc_pkg::DEEP_SUSPEND_BIT];
      pll_next  = reg_wdata[uefcc_pkg::PLL_SOURCE_BIT];
      xtal_next = reg_wdata[uefcc_pkg::CRYSTAL_FREQ_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_reg  <= uefcc_pkg::CLOCK_CTRL_RESET[uefcc_pkg::SEL_MSB:uefcc_pkg::SEL_LSB];
      gate_reg <= uefcc_pkg::CLOCK_CTRL_RESET[uefcc_pkg::USB_CLK_GATE_BIT];
      susp_reg <= uefcc_pkg::CLOCK_CTRL_RESET[uefcc_pkg::DEEP_SUSPEND_BIT];
      pll_reg  <= uefcc_pkg::CLOCK_CTRL_RESET[uefcc_pkg::PLL_SOURCE_BIT];
      xtal_reg <= uefcc_pkg::CLOCK_CTRL_RESET[uefcc_pkg::CRYSTAL_FREQ_BIT];
    end
    else
    begin
      sel_reg  <= sel_next;
      gate_reg <= gate_next;
      susp_reg <= susp_next;
      pll_reg  <= pll_next;
      xtal_reg <= xtal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO selection check
  logic       fvalid_reg;
  logic       fvalid_next;

  always_comb
  begin
    fvalid_next = sel_valid(sel_next);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fvalid_reg <= 1'b1;
    end
    else
    begin
      fvalid_reg <= fvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask register
  logic [2:0] imask_reg;
  logic [2:0] imask_next;

  always_comb
  begin
    imask_next = imask_reg;
    if (wr_mask)
    begin
      imask_next = reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      imask_reg <= uefcc_pkg::IRQ_MASK_RESET[2:0];
    end
    else
    begin
      imask_reg <= imask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status register
  logic [2:0] istat_reg;
  logic [2:0] istat_next;

  always_comb
  begin
    istat_next = sticky_update(istat_reg, 3'h0, ep_access);
    if (wr_istat)
    begin
      istat_next = sticky_update(istat_reg, reg_wdata[2:0], ep_access);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      istat_reg <= 3'h0;
    end
    else
    begin
      istat_reg <= istat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output
  logic       irq_reg;
  logic       irq_next;

  always_comb
  begin
    irq_next = irq_gate && (|(istat_next & imask_next));
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_status)
    begin
      rdata_next = pad_low3(fif.flags);
    end
    else if (rd_ctrl)
    begin
      rdata_next = pack_ctrl(sel_reg, gate_reg, susp_reg, pll_reg, xtal_reg);
    end
    else if (rd_mask)
    begin
      rdata_next = pad_low3(imask_reg);
    end
    else if (rd_istat)
    begin
      rdata_next = pad_low3(istat_reg);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata               = rdata_reg;
  assign usb_irq                 = irq_reg;
  assign fifo_endpoint_select    = sel_reg;
  assign fifo_select_valid       = fvalid_reg;
  assign usb_clock_gate          = gate_reg;
  assign deep_suspend_power      = susp_reg;
  assign pll_clock_source_select = pll_reg;
  assign crystal_freq_select     = xtal_reg;
endmodule
`default_nettype wire

// *** inc/uefcc_pkg.sv ***
// Package with register map and field constants for endpoint flags and clock control
`default_nettype none
package uefcc_pkg;
  localparam logic [7:0] EP_STATUS_OFFSET   = 8'h21;
  localparam logic [7:0] CLOCK_CTRL_OFFSET  = 8'h22;
  localparam logic [7:0] IRQ_MASK_OFFSET    = 8'h30;
  localparam logic [7:0] IRQ_STATUS_OFFSET  = 8'h31;
  localparam int         EP_FLAG_LSB        = 0;
  localparam int         EP_COUNT           = 3;
  localparam int         SEL_LSB            = 0;
  localparam int         SEL_MSB            = 2;
  localparam int         USB_CLK_GATE_BIT   = 3;
  localparam int         DEEP_SUSPEND_BIT   = 4;
  localparam int         PLL_SOURCE_BIT     = 5;
  localparam int         CRYSTAL_FREQ_BIT   = 6;
  localparam logic [7:0] EP_STATUS_RESET    = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_RESET   = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET     = 8'h00;
  localparam logic [6:0] CLOCK_CTRL_MASK    = 7'h7f;
  localparam logic [2:0] SEL_EP0            = 3'h0;
  localparam logic [2:0] SEL_EP1            = 3'h1;
  localparam logic [2:0] SEL_EP2            = 3'h2;
endpackage
`default_nettype wire

// *** inc/uefcc_flag_if.sv ***
// Interface carrying endpoint flag events and software clears
`timescale 1ns/10ps
`default_nettype none
interface uefcc_flag_if;
  logic [2:0] set_pulse;
  logic [2:0] clr_mask;
  logic       wr_en;
  logic [2:0] flags;
  modport ctrl (output set_pulse, output clr_mask, output wr_en, input flags);
  modport flag (input set_pulse, input clr_mask, input wr_en, output flags);
endinterface
`default_nettype wire

// *** logic/uefcc_flags.sv ***
// Sticky endpoint request flags with set over clear priority
`timescale 1ns/10ps
`default_nettype none
module uefcc_flags
(
  input  wire logic   ref_clk,
  input  wire logic   reset_n,
  uefcc_flag_if.flag  fl
);
  logic [2:0] flag_reg;
  logic [2:0] flag_next;

  always_comb
  begin
    flag_next = flag_reg;
    if (fl.wr_en)
    begin
      flag_next = fl.clr_mask;
    end
    flag_next = flag_next | fl.set_pulse;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_reg <= uefcc_pkg::EP_STATUS_RESET[2:0];
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign fl.flags = flag_reg;
endmodule
`default_nettype wire

// *** testbench/uefcc_checker.sv ***
// Checker for the endpoint flag and clock control bank
`timescale 1ns/10ps
`default_nettype none
module uefcc_checker
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       usb_int_enable,
  input wire logic       stack_full,
  input wire logic       usb_irq,
  input wire logic [2:0] fifo_endpoint_select,
  input wire logic       fifo_select_valid,
  input wire logic       usb_clock_gate,
  input wire logic       deep_suspend_power,
  input wire logic       pll_clock_source_select,
  input wire logic       crystal_freq_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr;
    reg_wr && reg_addr == uefcc_pkg::CLOCK_CTRL_OFFSET;
  endsequence
  a_sel_write: assert property (s_ctl_wr |=> fifo_endpoint_select == $past(reg_wdata[2:0]))
    else $error("select not loaded");
  a_sel_valid: assert property (fifo_select_valid == (fifo_endpoint_select < 3'h3))
    else $error("select valid wrong");
  a_gate_write: assert property (s_ctl_wr |=> usb_clock_gate == $past(reg_wdata[3]))
    else $error("clock gate not loaded");
  a_susp_write: assert property (s_ctl_wr |=> deep_suspend_power == $past(reg_wdata[4]))
    else $error("suspend bit not loaded");
  a_pll_write: assert property (s_ctl_wr |=> pll_clock_source_select == $past(reg_wdata[5]))
    else $error("clock source not loaded");
  a_xtal_write: assert property (s_ctl_wr |=> crystal_freq_select == $past(reg_wdata[6]))
    else $error("crystal bit not loaded");
  a_upper_zero: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  a_irq_blocked: assert property (!usb_int_enable |=> !usb_irq)
    else $error("irq while disabled");
  a_irq_stack: assert property (stack_full |=> !usb_irq)
    else $error("irq while stack full");
endmodule
bind uefcc_top uefcc_checker uefcc_checker_inst (.*);
`default_nettype wire

// *** testbench/uefcc_engine_model.sv ***
// Engine model that pulses endpoint access
`timescale 1ns/10ps
`default_nettype none
module uefcc_engine_model
(
  input  wire logic       ref_clk,
  input  wire logic [2:0] hit,
  output logic      [2:0] ep_access
);
  always_ff @(posedge ref_clk)
    ep_access <= hit;
endmodule
`default_nettype wire

// *** testbench/test_usb_endpoint_flags_clock_ctrl.sv ***
// Bench for the endpoint flag and clock control bank
`timescale 1ns/10ps
`default_nettype none
module test_usb_endpoint_flags_clock_ctrl;
  logic       ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, usb_int_enable = 0;
  logic       stack_full = 0, usb_irq, fifo_select_valid, usb_clock_gate, deep_suspend_power;
  logic       pll_clock_source_select, crystal_freq_select;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
  logic [2:0] hit = 0, ep_access, fifo_endpoint_select;
  int         n_errors = 0, n_tests = 0, seed = 1, i;
  logic [7:0] pins;
  assign pins = {1'b0, crystal_freq_select, pll_clock_source_select, deep_suspend_power,
                 usb_clock_gate, fifo_endpoint_select};
  always #5 ref_clk = ~ref_clk;
  uefcc_engine_model uefcc_engine_model_inst (.*);
  uefcc_top uefcc_top_inst (.*);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
    exp_ctrl = {1'b0, d[6:0]};
  endfunction
  function automatic logic [7:0] exp_valid(input logic [2:0] s);
    exp_valid = {7'h0, (s == 3'h0) || (s == 3'h1) || (s == 3'h2)};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(8'h21, 8'h00, "status_reset");
    rd(8'h22, 8'h00, "ctrl_reset");
    for (i = 0; i < 24; i++)
    begin
      v = 8'($random(seed));
      if (i < 8) v[2:0] = i[2:0];
      wr(8'h22, v);
      check("sel_valid", {7'h0, fifo_select_valid}, exp_valid(v[2:0]));
      check("ctrl_pins", pins, exp_ctrl(v));
      rd(8'h22, exp_ctrl(v), "ctrl_read");
    end
    $display("test control done");
    wr(8'h22, 8'h08);
    wr(8'h22, 8'h10);
    check("suspend", pins, exp_ctrl(8'h10));
    wr(8'h22, 8'h08);
    check("resume", pins, exp_ctrl(8'h08));
    $display("test suspend done");
    wr(8'h30, 8'h07);
    usb_int_enable <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      hit <= 3'h1 << i;
      @(posedge ref_clk);
      hit <= 3'h0;
      repeat (2) @(posedge ref_clk);
      check("irq_raised", {7'h0, usb_irq}, 8'h01);
      rd(8'h21, 8'h07 >> (2 - i), "flag_set");
    end
    stack_full <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("irq_stack_full", {7'h0, usb_irq}, 8'h00);
    stack_full <= 1'b0;
    wr(8'h31, 8'h07);
    check("irq_cleared", {7'h0, usb_irq}, 8'h00);
    rd(8'h21, 8'h07, "flag_sticky");
    hit <= 3'h2;
    @(posedge ref_clk);
    hit <= 3'h0;
    wr(8'h21, 8'hf8);
    rd(8'h21, 8'h02, "set_beats_clear");
    wr(8'h21, 8'h00);
    rd(8'h21, 8'h00, "flag_clear");
    rd(8'h40, 8'h00, "unmapped");
    $display("test flags done");
    tally_and_finish;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
